// *** design/acs_pkg.sv ***
// constants and types for the converter command and result word logic
package acs_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int           CMD_W        = 8;
  localparam int           CMD_OP_BIT   = 7;
  localparam int           CMD_CONT_BIT = 6;
  localparam int           CMD_PTR_HI   = 5;
  localparam int           CMD_PTR_LO   = 3;
  localparam int           CMD_TYPE_HI  = 2;
  localparam int           CMD_TYPE_LO  = 0;
  localparam logic [7:0]   SYNC1_BYTE   = 8'hFF;
  localparam logic [7:0]   SYNC0_BYTE   = 8'hFE;
  localparam logic [7:0]   EXIT_BYTE    = 8'hFF;
  localparam logic [2:0]   OP_CONVERT   = 3'h0;

  // ----------------------------------------------------------------
  // serial frame counts
  // ----------------------------------------------------------------
  localparam logic [5:0]   FLAG_CLKS    = 6'h08;
  localparam logic [5:0]   WORD_CLKS    = 6'h20;
  localparam int           SYNC_AMBIG_CYCLES = 8;

  // ----------------------------------------------------------------
  // result word layout
  // ----------------------------------------------------------------
  localparam int           RES_W        = 32;
  localparam int           CODE_W       = 24;
  localparam int           CHAN_W       = 2;
  localparam logic [4:0]   UNUSED_ZERO  = 5'h00;
  localparam logic [23:0]  CODE_UNI_MAX = 24'hFFFFFF;
  localparam logic [23:0]  CODE_UNI_MIN = 24'h000000;
  localparam logic [23:0]  CODE_BIP_MAX = 24'h7FFFFF;
  localparam logic [23:0]  CODE_BIP_MIN = 24'h800000;
  localparam logic [31:0]  RES_RESET    = 32'h00000000;

  // ----------------------------------------------------------------
  // setup defaults
  // ----------------------------------------------------------------
  localparam int           NUM_SETUPS   = 8;
  localparam logic [1:0]   CHAN_DEFAULT = 2'h0;
  localparam logic         BIP_DEFAULT  = 1'b0;

  // ----------------------------------------------------------------
  // serial port states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_FLAG  = 3'b010,
    ST_SHIFT = 3'b011,
    ST_CAL   = 3'b100
  } acs_state_e;

endpackage

// *** design/acs_top.sv ***
// serial command decode, conversion sequencing and result word formatting
`timescale 1ns/10ps

// ------------------------------------------------------------------
// result buffer
// ------------------------------------------------------------------
module acs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_ready & out_valid;
  assign out_data = mem_r[rd_ptr_r];

  always_comb
  begin
    count_nxt = count_r;
    if (push & ~pop)
    begin
      count_nxt = count_r + CNT_ONE;
    end
    else if (pop & ~push)
    begin
      count_nxt = count_r - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= CNT_ZERO;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != CNT_FULL);
      out_valid <= (count_nxt != CNT_ZERO);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
// Overview of operation
// - setup pointer picks one of eight setups; setup n sits in register n/2.
// - byte 10000000 runs one single conversion with setup 0.
// - single result: output low, 40 clocks read it, then back to command mode.
// - byte 11010000 starts continuous conversions with setup 2; each result pulls output low.
// - continuous mode keeps converting whether or not a result is read.
// - byte 10011001 runs one self offset calibration, output low when finished.
// - unwritten setups default to physical channel 1.
// - flush the filter when consecutive conversions change physical channel.
// - keep filter state when consecutive conversions use the same channel.
// - same clock and reset give identical start latency, within 8 cycles.
// - 32-bit result word, most significant bit first, code then flag byte.
// - straight binary when unipolar, two's complement when bipolar.
// - unipolar saturates at FFFFFF and 000000.
// - bipolar at or below negative full scale reads 800000.
// - bits 31 to 8 carry the latest code.
// - bits 7 to 3 always zero.
// - bit 2 flags input beyond the range.
// - bits 1 to 0 give channel: 00, 01, 10 for channels 1 to 3.
// - channel indicator 11 means physical channel 4.
// - first 8 read clocks clear the ready flag with input zero; 32 shift the word.
// - all ones in first 8 clocks ends continuous mode after this read.
module acs_top
  import acs_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // serial port
  input  wire logic              sclk,
  input  wire logic              serial_input_line,
  input  wire logic              cs_b,
  output logic                   serial_output_line,
  output logic                   sdo_oe,
  // setup table write
  input  wire logic              setup_wr_en,
  input  wire logic [2:0]        setup_wr_idx,
  input  wire logic [1:0]        setup_wr_chan,
  input  wire logic              setup_wr_bipolar,
  input  wire logic              offset_gain_source_select,
  // converter core control
  output logic                   conv_start,
  output logic                   conv_stop,
  output logic                   conv_continuous,
  output logic [1:0]             conv_chan,
  output logic                   conv_bipolar,
  output logic [1:0]             conv_setup_reg,
  output logic                   filter_flush,
  output logic                   cal_start,
  output logic [2:0]             cal_type,
  output logic                   cal_source,
  input  wire logic              cal_done,
  // converter core results
  input  wire logic              res_valid,
  input  wire logic [CODE_W-1:0] res_code,
  input  wire logic              res_over_pos,
  input  wire logic              res_under,
  output logic                   res_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acs_state_e       state_r;
  logic             sclk_s1, sclk_s2, sclk_d;
  logic             sdi_s1, sdi_s2;
  logic             cs_s1, cs_s2;
  logic             rise, fall;
  logic [5:0]       bit_cnt_r;
  logic [6:0]       shin_r;
  logic [7:0]       rx_byte;
  logic [RES_W-1:0] word_r;
  logic [RES_W-1:0] word_sh_r;
  logic             exit_r;
  logic [1:0]       setup_chan_r [NUM_SETUPS];
  logic             setup_bip_r  [NUM_SETUPS];
  logic [1:0]       last_chan_r;
  logic             last_valid_r;
  logic [2:0]       ptr;
  logic [2:0]       op_type;
  logic             byte_end;
  logic             cmd_take, cmd_op, cmd_conv, cmd_cal;
  logic             word_done;
  logic             drain_ready;
  logic             buf_valid;
  logic [RES_W-1:0] buf_data;
  logic [RES_W-1:0] fmt_word;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
    end
    else if (clk_en)
    begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      sdi_s1  <= serial_input_line;
      sdi_s2  <= sdi_s1;
      cs_s1   <= cs_b;
      cs_s2   <= cs_s1;
    end
  end

  assign rise = sclk_s2 & ~sclk_d & ~cs_s2;
  assign fall = ~sclk_s2 & sclk_d & ~cs_s2;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign rx_byte  = {shin_r, sdi_s2};
  assign byte_end = rise & (bit_cnt_r == FLAG_CLKS - 6'h01);
  assign ptr      = rx_byte[CMD_PTR_HI:CMD_PTR_LO];
  assign op_type  = rx_byte[CMD_TYPE_HI:CMD_TYPE_LO];
  assign cmd_take = (state_r == ST_CMD) & byte_end;
  assign cmd_op   = rx_byte[CMD_OP_BIT] & (rx_byte != SYNC1_BYTE) & (rx_byte != SYNC0_BYTE);
  assign cmd_conv = cmd_take & cmd_op & (op_type == OP_CONVERT);
  assign cmd_cal  = cmd_take & cmd_op & (op_type != OP_CONVERT);
  assign word_done = (state_r == ST_SHIFT) & rise & (bit_cnt_r == WORD_CLKS - 6'h01);
  assign drain_ready = (state_r != ST_SHIFT);

  // ----------------------------------------------------------------
  // setup table
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_SETUPS; i++)
      begin
        setup_chan_r[i] <= CHAN_DEFAULT;
        setup_bip_r[i]  <= BIP_DEFAULT;
      end
    end
    else if (clk_en && setup_wr_en)
    begin
      setup_chan_r[setup_wr_idx] <= setup_wr_chan;
      setup_bip_r[setup_wr_idx]  <= setup_wr_bipolar;
    end
  end

  // ----------------------------------------------------------------
  // result word formatting
  // ----------------------------------------------------------------
  always_comb
  begin
    fmt_word = {res_code, UNUSED_ZERO, 1'b0, conv_chan};
    if (res_over_pos)
    begin
      fmt_word[RES_W-1 -: CODE_W] = conv_bipolar ? CODE_BIP_MAX : CODE_UNI_MAX;
      fmt_word[CHAN_W] = 1'b1;
    end
    else if (res_under)
    begin
      fmt_word[RES_W-1 -: CODE_W] = conv_bipolar ? CODE_BIP_MIN : CODE_UNI_MIN;
      fmt_word[CHAN_W] = 1'b1;
    end
  end

  acs_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (res_valid),
    .in_data   (fmt_word),
    .in_ready  (res_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (drain_ready)
  );

  // ----------------------------------------------------------------
  // serial port sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r    <= ST_CMD;
      bit_cnt_r  <= 6'h00;
      shin_r     <= 7'h00;
      word_r     <= RES_RESET;
      word_sh_r  <= RES_RESET;
      exit_r     <= 1'b0;
      serial_output_line        <= 1'b1;
      sdo_oe     <= 1'b0;
    end
    else if (clk_en)
    begin
      sdo_oe <= ~cs_s2;
      if (rise)
      begin
        shin_r <= rx_byte[6:0];
      end
      if (buf_valid && drain_ready)
      begin
        word_r <= buf_data;
      end
      case (state_r)
        ST_CMD:
        begin
          if (rise)
          begin
            serial_output_line        <= 1'b1;
            bit_cnt_r  <= byte_end ? 6'h00 : bit_cnt_r + 6'h01;
          end
          if (cmd_conv)
          begin
            state_r <= ST_WAIT;
          end
          else if (cmd_cal)
          begin
            state_r <= ST_CAL;
          end
        end
        ST_WAIT:
        begin
          serial_output_line <= 1'b1;
          if (buf_valid)
          begin
            state_r   <= ST_FLAG;
            bit_cnt_r <= 6'h00;
            serial_output_line       <= 1'b0;
          end
        end
        ST_FLAG:
        begin
          serial_output_line <= 1'b0;
          if (rise)
          begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
          end
          if (byte_end)
          begin
            state_r   <= ST_SHIFT;
            bit_cnt_r <= 6'h00;
            word_sh_r <= word_r;
            exit_r    <= conv_continuous & (rx_byte == EXIT_BYTE);
          end
        end
        ST_SHIFT:
        begin
          if (fall)
          begin
            serial_output_line       <= word_sh_r[RES_W-1];
            word_sh_r <= {word_sh_r[RES_W-2:0], 1'b0};
          end
          if (rise)
          begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
          end
          if (word_done)
          begin
            bit_cnt_r <= 6'h00;
            serial_output_line       <= 1'b1;
            state_r   <= (conv_continuous && !exit_r) ? ST_WAIT : ST_CMD;
          end
        end
        ST_CAL:
        begin
          serial_output_line <= 1'b1;
          if (cal_done)
          begin
            state_r    <= ST_CMD;
            serial_output_line        <= 1'b0;
            bit_cnt_r  <= 6'h00;
          end
        end
        default:
        begin
          state_r <= ST_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter core control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_start      <= 1'b0;
      conv_stop       <= 1'b0;
      conv_continuous <= 1'b0;
      conv_chan       <= CHAN_DEFAULT;
      conv_bipolar    <= BIP_DEFAULT;
      conv_setup_reg  <= 2'h0;
      filter_flush    <= 1'b0;
      cal_start       <= 1'b0;
      cal_type        <= OP_CONVERT;
      cal_source      <= 1'b0;
      last_chan_r     <= CHAN_DEFAULT;
      last_valid_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      conv_start   <= cmd_conv;
      cal_start    <= cmd_cal;
      filter_flush <= 1'b0;
      conv_stop    <= word_done & exit_r;
      if (cmd_conv || cmd_cal)
      begin
        conv_chan      <= setup_chan_r[ptr];
        conv_bipolar   <= setup_bip_r[ptr];
        conv_setup_reg <= ptr[2:1];
      end
      if (cmd_conv)
      begin
        conv_continuous <= rx_byte[CMD_CONT_BIT];
        filter_flush    <= ~last_valid_r | (setup_chan_r[ptr] != last_chan_r);
        last_chan_r     <= setup_chan_r[ptr];
        last_valid_r    <= 1'b1;
      end
      if (cmd_cal)
      begin
        conv_continuous <= 1'b0;
        cal_type        <= op_type;
        cal_source      <= offset_gain_source_select;
        last_valid_r    <= 1'b0;
      end
      if (word_done && exit_r)
      begin
        conv_continuous <= 1'b0;
      end
    end
  end

endmodule

// *** testbench/acs_top_asserts.sv ***
// assertions on the command and result ports
`timescale 1ns/10ps

// ----------------------------------------
// checker
// ----------------------------------------
module acs_top_chk
  import acs_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // serial port
  input wire logic       cs_b,
  input wire logic       sdo_oe,
  // core control
  input wire logic       offset_gain_source_select,
  input wire logic       conv_start,
  input wire logic       conv_stop,
  input wire logic       conv_continuous,
  input wire logic       filter_flush,
  input wire logic       cal_start,
  input wire logic [2:0] cal_type,
  input wire logic       cal_source,
  // results
  input wire logic       res_valid,
  input wire logic       res_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  one_op_a: assert property (!(conv_start && cal_start))
    else $error("conversion and calibration started together");
  flush_start_a: assert property (filter_flush |-> conv_start)
    else $error("filter flush without a conversion start");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  cal_kind_a: assert property (cal_start |-> cal_type != OP_CONVERT)
    else $error("calibration started with conversion type");
  cal_source_a: assert property (cal_start |-> cal_source == $past(offset_gain_source_select))
    else $error("calibration source not taken from select input");
  cont_entry_a: assert property ($rose(conv_continuous) |-> conv_start || $past(conv_start))
    else $error("continuous mode entered without a command");
  cont_exit_a: assert property (conv_stop |=> !conv_continuous)
    else $error("continuous mode kept after stop");
  cont_keep_a: assert property ($fell(conv_continuous) |-> conv_stop || $past(conv_stop))
    else $error("continuous mode left without exit byte");
  ready_hold_a: assert property (res_ready && !res_valid |=> res_ready)
    else $error("result buffer filled with no input");
  oe_on_a: assert property ($fell(cs_b) |-> ##[1:5] sdo_oe)
    else $error("output not enabled after select");
  oe_off_a: assert property (cs_b [*5] |-> !sdo_oe)
    else $error("output enabled while deselected");

  cov_single: cover property (conv_start ##1 !conv_continuous);
  cov_cal: cover property (cal_start);
  cov_stop: cover property (conv_stop);
  cov_full: cover property (res_valid && !res_ready);
endmodule

bind acs_top acs_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .sdo_oe(sdo_oe),
  .offset_gain_source_select(offset_gain_source_select), .conv_start(conv_start),
  .conv_stop(conv_stop), .conv_continuous(conv_continuous), .filter_flush(filter_flush),
  .cal_start(cal_start), .cal_type(cal_type), .cal_source(cal_source),
  .res_valid(res_valid), .res_ready(res_ready)
);

// *** testbench/acs_host.sv ***
// host model of the four-wire serial port
`timescale 1ns/10ps

// ----------------------------------------
// host model
// ----------------------------------------
module acs_host (
  // serial port
  output logic      sclk,
  output logic      serial_input_line,
  output logic      cs_b,
  input  wire logic serial_output_line
);
  initial
  begin
    sclk = 1'b0;
    serial_input_line  = 1'b0;
    cs_b = 1'b1;
  end

  // one link clock: data set on the low phase, output sampled at the rise
  task automatic bit_io(input logic d, output logic q);
    serial_input_line = d;
    #32 sclk = 1'b1;
    q = serial_output_line;
    #32 sclk = 1'b0;
  endtask

  task automatic select;
    #1.25 cs_b = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic q;
    // step off the system clock grid so no pin moves on its edge
    #1.25;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q);
    serial_input_line = ~b[0];
  endtask

  // 8 flag clocks carry the mode byte, 32 more shift the word out
  task automatic read_word(input logic [7:0] mode, output logic [31:0] w);
    logic q;
    #1.25;
    for (int i = 7; i >= 0; i--)
      bit_io(mode[i], q);
    for (int i = 31; i >= 0; i--)
    begin
      bit_io(1'b0, q);
      w[i] = q;
    end
    serial_input_line = 1'b1;
  endtask
endmodule

// *** testbench/acs_top_tb_top.sv ***
// self-checking bench for the command and result word block
`timescale 1ns/10ps

// ----------------------------------------
// bench
// ----------------------------------------
module acs_top_tb_top
  import acs_pkg::*;
;
  localparam int          DEPTH = 4;
  localparam logic [15:0] CHS   = 16'hFB43;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic        setup_wr_en = 1'b0;
  logic [2:0]  setup_wr_idx = 3'h0;
  logic [1:0]  setup_wr_chan = 2'h0;
  logic        setup_wr_bipolar = 1'b0;
  logic        offset_gain_source_select = 1'b0;
  logic        cal_done = 1'b0;
  logic        res_valid = 1'b0;
  logic [23:0] res_code = 24'h000000;
  logic        res_over_pos = 1'b0;
  logic        res_under = 1'b0;
  logic        sclk, serial_input_line, cs_b, serial_output_line, sdo_oe, res_ready;
  logic        conv_start, conv_stop, conv_continuous, filter_flush, cal_start, cal_source, conv_bipolar;
  logic [1:0]  conv_chan, conv_setup_reg;
  logic [2:0]  cal_type;
  logic        last_flush = 1'b0;
  int          errors = 0, checks = 0, n_start = 0, n_cal = 0, n_stop = 0;

  acs_top #(.FIFO_DEPTH(DEPTH)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .sclk(sclk), .serial_input_line(serial_input_line), .cs_b(cs_b),
    .serial_output_line(serial_output_line), .sdo_oe(sdo_oe), .setup_wr_en(setup_wr_en), .setup_wr_idx(setup_wr_idx),
    .setup_wr_chan(setup_wr_chan), .setup_wr_bipolar(setup_wr_bipolar),
    .offset_gain_source_select(offset_gain_source_select), .conv_start(conv_start), .conv_stop(conv_stop),
    .conv_continuous(conv_continuous), .conv_chan(conv_chan), .conv_bipolar(conv_bipolar),
    .conv_setup_reg(conv_setup_reg), .filter_flush(filter_flush), .cal_start(cal_start),
    .cal_type(cal_type), .cal_source(cal_source), .cal_done(cal_done), .res_valid(res_valid),
    .res_code(res_code), .res_over_pos(res_over_pos), .res_under(res_under), .res_ready(res_ready)
  );
  acs_host host (.sclk(sclk), .serial_input_line(serial_input_line), .cs_b(cs_b), .serial_output_line(serial_output_line));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (conv_start === 1'b1)
    begin
      n_start++;
      last_flush = filter_flush;
    end
    if (cal_start === 1'b1)
      n_cal++;
    if (conv_stop === 1'b1)
      n_stop++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] exp_w(input logic [23:0] c, input logic o, u, b, input logic [1:0] ch);
    logic [23:0] e;
    e = u ? (b ? CODE_BIP_MIN : CODE_UNI_MIN) : o ? (b ? CODE_BIP_MAX : CODE_UNI_MAX) : c;
    return {e, UNUSED_ZERO, o | u, ch};
  endfunction

  task automatic give(input logic [23:0] c, input logic o, input logic u);
    @(posedge sys_clk);
    res_code <= c;
    res_over_pos <= o;
    res_under <= u;
    res_valid <= 1'b1;
    do
      @(posedge sys_clk);
    while (res_ready !== 1'b1);
    res_valid <= 1'b0;
  endtask

  task automatic wait_low;
    int n;
    n = 0;
    while (serial_output_line !== 1'b0 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("ready flag", {31'h0, serial_output_line}, 32'h0);
  endtask

  task automatic t_conv(input logic [2:0] p, input logic [1:0] ch, input logic b, o, u, fl);
    int          s;
    logic [31:0] w;
    logic [23:0] c;
    s = n_start;
    c = {16'hC0DE, 5'h00, p};
    host.send_byte({2'b10, p, OP_CONVERT});
    repeat (4) @(posedge sys_clk);
    chk("start count", n_start, s + 1);
    chk("flush", {31'h0, last_flush}, {31'h0, fl});
    chk("channel", {30'h0, conv_chan}, {30'h0, ch});
    chk("polarity", {31'h0, conv_bipolar}, {31'h0, b});
    chk("setup reg", {30'h0, conv_setup_reg}, {29'h0, p} >> 1);
    chk("single", {31'h0, conv_continuous}, 32'h0);
    give(c, o, u);
    wait_low();
    host.read_word(8'h00, w);
    chk("word", w, exp_w(c, o, u, b, ch));
    repeat (4) @(posedge sys_clk);
    chk("idle high", {31'h0, serial_output_line}, 32'h1);
  endtask

  task automatic t_reset;
    chk("sdo reset", {31'h0, serial_output_line}, 32'h1);
    chk("oe reset", {31'h0, sdo_oe}, 32'h0);
    chk("ready reset", {31'h0, res_ready}, 32'h1);
    host.select();
    repeat (8) @(posedge sys_clk);
    chk("oe on", {31'h0, sdo_oe}, 32'h1);
  endtask

  task automatic t_defaults;
    int s;
    s = n_start;
    host.send_byte(8'h00);
    repeat (4) @(posedge sys_clk);
    chk("refused", n_start, s);
    t_conv(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    t_conv(3'h7, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_setups;
    logic [1:0] prev;
    prev = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      setup_wr_en <= 1'b1;
      setup_wr_idx <= i[2:0];
      setup_wr_chan <= CHS[2*i+:2];
      setup_wr_bipolar <= (i == 5 || i == 6);
    end
    @(posedge sys_clk);
    setup_wr_en <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      t_conv(i[2:0], CHS[2*i+:2], i == 5 || i == 6, i == 3 || i == 6, i == 5 || i == 7,
             CHS[2*i+:2] != prev);
      prev = CHS[2*i+:2];
    end
  endtask

  task automatic t_cont;
    int          s, n;
    logic [31:0] w;
    logic [23:0] c;
    s = n_stop;
    n = 0;
    host.send_byte(8'hD0);
    repeat (4) @(posedge sys_clk);
    chk("cont on", {31'h0, conv_continuous}, 32'h1);
    chk("cont setup", {30'h0, conv_setup_reg}, 32'h1);
    chk("cont flush", {31'h0, last_flush}, 32'h1);
    give(24'h111111, 1'b0, 1'b0);
    repeat (5) @(posedge sys_clk);
    give(24'h222222, 1'b0, 1'b0);
    wait_low();
    fork
      host.read_word(8'h00, w);
      begin
        #(64 * 12);
        @(posedge sys_clk);
        res_code <= 24'h300000;
        res_valid <= 1'b1;
        repeat (20)
        begin
          @(posedge sys_clk);
          if (res_ready === 1'b1)
            n++;
          res_code <= 24'h300000 + 24'(n);
        end
        do
          @(posedge sys_clk);
        while (res_ready !== 1'b1);
        res_valid <= 1'b0;
      end
    join
    chk("skipped", w, {24'h222222, 8'h00});
    chk("fill count", n, DEPTH);
    chk("kept on", {31'h0, conv_continuous}, 32'h1);
    wait_low();
    chk("drained", {31'h0, res_ready}, 32'h1);
    c = 24'h300000 + 24'(DEPTH);
    host.read_word(8'hFF, w);
    chk("latest", w, {c, 8'h00});
    repeat (4) @(posedge sys_clk);
    chk("stop pulse", n_stop, s + 1);
    chk("cont off", {31'h0, conv_continuous}, 32'h0);
    chk("command mode", {31'h0, serial_output_line}, 32'h1);
  endtask

  task automatic t_cal;
    int s;
    s = n_cal;
    host.send_byte(8'h99);
    repeat (4) @(posedge sys_clk);
    chk("cal start", n_cal, s + 1);
    chk("cal type", {29'h0, cal_type}, 32'h1);
    chk("cal source", {31'h0, cal_source}, 32'h0);
    @(posedge sys_clk);
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
    wait_low();
    t_conv(3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
  endtask

  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_defaults();
    t_setups();
    t_cont();
    t_cal();
    end_of_test();
  end
endmodule
